// [shared/ibcs_pkg.sv]
package ibcs_pkg;

  // ****************************************
  // Cycle owners
  // ****************************************
  localparam logic [1:0] OWN_CPU  = 2'h0;  // Processor cycle
  localparam logic [1:0] OWN_DMA  = 2'h1;  // DMA cycle
  localparam logic [1:0] OWN_RFSH = 2'h2;  // Refresh cycle

  // ****************************************
  // Wait states (one T2 is one core clock)
  // ****************************************
  localparam int WAIT_8BIT  = 4;  // Default 8-bit cycle waits
  localparam int WAIT_16BIT = 1;  // Default 16-bit cycle waits
  localparam int WAIT_ROM   = 1;  // BIOS ROM: exactly one wait

  // ****************************************
  // Address decode
  // ****************************************
  localparam logic [15:0] KBD_DATA_PORT = 16'h0060;  // Keyboard data port
  localparam logic [15:0] KBD_CMD_PORT  = 16'h0064;  // Keyboard command port
  localparam logic [3:0]  LOW_MB_TOP    = 4'h0;      // addr[23:20] below 1 MB
  localparam logic [3:0]  ROM_SEG       = 4'hF;      // addr[19:16] of BIOS ROM

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic STRAP_RESET = 1'b1;  // Strap value before first sample

  // ****************************************
  // Cycle engine states
  // ****************************************
  typedef enum logic [3:0] {
    IBCS_IDLE = 4'b0001,  // Waiting for request
    IBCS_ADDR = 4'b0010,  // T1, address latch pulse
    IBCS_CMD  = 4'b0100,  // Command active, T2 states
    IBCS_HOLD = 4'b1000   // Command off, data hold
  } ibcs_state_t;

endpackage

// [design/ibcs_decode.sv]
`timescale 1ns/100ps
module ibcs_decode (
  input  wire logic [23:0] addr,
  input  wire logic        is_io,
  input  wire logic        kbd_disable,
  output logic             rom_hit,
  output logic             kbd_hit,
  output logic             low_mb
);

  // ****************************************
  // Decode of a request address
  // ****************************************
  wire logic below_mb;  // Memory below one megabyte
  wire logic kbd_port;  // I/O to either keyboard port

  assign below_mb = addr[23:20] == ibcs_pkg::LOW_MB_TOP;
  assign kbd_port = addr[15:0] == ibcs_pkg::KBD_DATA_PORT || addr[15:0] == ibcs_pkg::KBD_CMD_PORT;

  // Low megabyte flag only for memory cycles
  assign low_mb  = !is_io && below_mb;
  // BIOS ROM lives in the top segment of the first megabyte
  assign rom_hit = !is_io && below_mb && addr[19:16] == ibcs_pkg::ROM_SEG;
  // Keyboard select gated by the disable bit
  assign kbd_hit = is_io && kbd_port && !kbd_disable;

endmodule

// [design/ibcs_wait_ctr.sv]
`timescale 1ns/100ps
module ibcs_wait_ctr #(
  parameter int WW = 4
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          load,
  input  wire logic [WW-1:0] load_val,
  input  wire logic          fixed,
  input  wire logic          chan_ready,
  input  wire logic          zws_en,
  input  wire logic          zws_n,
  output logic               first,
  output logic               last
);

  // ****************************************
  // Wait-state counter
  // ****************************************
  logic [WW-1:0] cnt;       // Waits still to run
  logic          first_q;   // Marks first T2 of the cycle

  // Load at cycle start, then count down to zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt     <= '0;
      first_q <= 1'b0;
    end else begin
      first_q <= load;
      if (load) begin
        cnt <= load_val;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign first = first_q;
  // Fixed-length cycles ignore ready and zero-wait, so the length never moves
  assign last = fixed ? (cnt == '0) :
                ((cnt == '0) && chan_ready) || (zws_en && !zws_n);

endmodule

// [design/ibcs_isa_cycle.sv]
`timescale 1ns/100ps
// How it works
// - Drive SA[1:0] except under ISA master
// - Sixteen-bit two-way ISA data path
// - Pulse ALE at each started cycle
// - Sample master's high byte enable
// - Drive strobes for CPU/DMA, else receive
// - Flag memory below one megabyte
// - Drive 16-bit memory select low for masters
// - 16-bit I/O select avoids byte split
// - Channel ready low stretches the cycle
// - Strap at reset picks shared input
// - BIOS ROM cycles take one wait
// - ROM enable from end of first to end of last T2
// - ROM may be 8 or 16 bits wide
// - Select also for ports 60h and 64h
// - Disable bit blocks keyboard select
module ibcs_isa_cycle #(
  parameter int W8  = ibcs_pkg::WAIT_8BIT,
  parameter int W16 = ibcs_pkg::WAIT_16BIT,
  parameter int WW  = 4
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Request side
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [1:0]  req_owner,
  input  wire logic        req_io,
  input  wire logic        req_write,
  input  wire logic        req_word,
  input  wire logic [23:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             done,
  output logic [15:0]      rd_data,
  // Board options
  input  wire logic        master_active,
  input  wire logic        rom_wide,
  input  wire logic        kbd_disable,
  input  wire logic        multipurpose_strap_zero,
  // ISA pins
  input  wire logic [1:0]  sa_in,
  output logic [1:0]       sa_out,
  output logic             sa_oe,
  input  wire logic [15:0] sd_in,
  output logic [15:0]      sd_out,
  output logic             sd_oe,
  output logic             ale,
  input  wire logic        sbhe_in_n,
  output logic             sbhe_out_n,
  output logic             sbhe_oe,
  input  wire logic [3:0]  cmd_in_n,
  output logic [3:0]       cmd_out_n,
  output logic             cmd_oe,
  output logic             low_megabyte_select_n,
  input  wire logic        mcs16_in_n,
  output logic             mcs16_out_n,
  output logic             mcs16_oe,
  input  wire logic        iocs16_n,
  input  wire logic        iochrdy,
  input  wire logic        zws_lrdy_in_n,
  output logic             local_ready_n,
  output logic             bios_rom_select_n,
  // Master-cycle samples
  output logic [1:0]       master_sa,
  output logic             master_sbhe_n,
  output logic [3:0]       master_cmd_n
);

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (W8 < 1 || W16 < 0 || W8 >= (1 << WW) || W16 >= (1 << WW)) begin : g_bad
      $error("wait counts do not fit the counter");
    end
  endgenerate

  localparam logic [WW-1:0] W8_V  = WW'(W8);                 // 8-bit waits
  localparam logic [WW-1:0] W16_V = WW'(W16);                // 16-bit waits
  localparam logic [WW-1:0] WROM_V = WW'(ibcs_pkg::WAIT_ROM); // ROM waits

  // ****************************************
  // State and latched request
  // ****************************************
  ibcs_pkg::ibcs_state_t state;       // Cycle engine state
  ibcs_pkg::ibcs_state_t next_state;  // Next engine state
  logic [23:0] cur_addr;   // Address of cycle
  logic [15:0] cur_wdata;  // Write data
  logic [1:0]  cur_owner;  // Owner of cycle
  logic        cur_io;     // I/O rather than memory
  logic        cur_write;  // Write rather than read
  logic        cur_word;   // Word requested
  logic        cur_rom;    // BIOS ROM cycle
  logic        cur_kbd;    // Keyboard port cycle
  logic        cur_lowmb;  // Memory below 1 MB
  logic        is16;       // Cycle runs 16 bits wide
  logic        hi_phase;   // Second byte of split word
  logic        strap;      // Latched strap, 1 = zero-wait input
  logic        rom_oe;     // ROM output enable
  logic        kbd_sel;    // Keyboard select active

  // ****************************************
  // Decode and timing helpers
  // ****************************************
  wire logic dec_rom;    // Request hits BIOS ROM
  wire logic dec_kbd;    // Request hits keyboard port
  wire logic dec_lowmb;  // Request below 1 MB
  wire logic take;       // Request accepted
  wire logic size16;     // Slave claims 16-bit width
  wire logic wait_first; // First T2 in progress
  wire logic wait_last;  // Last T2 in progress
  wire logic cmd_end;    // Command phase ends this edge
  wire logic split;      // Word needs two byte cycles
  wire logic finish;     // Whole transfer ends
  wire logic drive_cmd;  // Device owns the strobes
  wire logic in_cmd;     // Command phase
  wire logic [WW-1:0] wait_load;  // Waits for this cycle

  ibcs_decode u_decode (
    .addr        (req_addr),
    .is_io       (req_io),
    .kbd_disable (kbd_disable),
    .rom_hit     (dec_rom),
    .kbd_hit     (dec_kbd),
    .low_mb      (dec_lowmb)
  );

  // Width claim: I/O select, memory select, or the ROM's own width
  assign size16 = cur_io ? !iocs16_n : (cur_rom ? rom_wide : !mcs16_in_n);
  assign wait_load = cur_rom ? WROM_V : (size16 && cur_word && !cur_addr[0] ? W16_V : W8_V);

  ibcs_wait_ctr #(
    .WW (WW)
  ) u_wait (
    .core_clk   (core_clk),
    .rst        (rst),
    .load       (state == ibcs_pkg::IBCS_ADDR),
    .load_val   (wait_load),
    .fixed      (cur_rom),
    .chan_ready (iochrdy),
    .zws_en     (strap),
    .zws_n      (zws_lrdy_in_n),
    .first      (wait_first),
    .last       (wait_last)
  );

  assign in_cmd  = state == ibcs_pkg::IBCS_CMD;
  assign cmd_end = in_cmd && wait_last;
  assign split   = cur_word && !is16 && !hi_phase;
  assign finish  = state == ibcs_pkg::IBCS_HOLD && !split;
  assign take    = req_valid && req_ready;
  // Refresh has no read or write strobe from us; masters own all strobes
  assign drive_cmd = !master_active && !(state != ibcs_pkg::IBCS_IDLE && cur_owner == ibcs_pkg::OWN_RFSH);

  // Requests only while idle and no master holds the bus
  assign req_ready = state == ibcs_pkg::IBCS_IDLE && !master_active;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ibcs_pkg::IBCS_IDLE: begin
        if (take) begin
          next_state = ibcs_pkg::IBCS_ADDR;
        end
      end
      ibcs_pkg::IBCS_ADDR: begin
        next_state = ibcs_pkg::IBCS_CMD;
      end
      ibcs_pkg::IBCS_CMD: begin
        if (wait_last) begin
          next_state = ibcs_pkg::IBCS_HOLD;
        end
      end
      ibcs_pkg::IBCS_HOLD: begin
        // Second byte starts a fresh cycle with its own address latch pulse
        next_state = split ? ibcs_pkg::IBCS_ADDR : ibcs_pkg::IBCS_IDLE;
      end
    endcase
  end

  // ****************************************
  // Engine registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ibcs_pkg::IBCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Latch request and its decode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_addr  <= '0;
      cur_wdata <= '0;
      cur_owner <= ibcs_pkg::OWN_CPU;
      cur_io    <= 1'b0;
      cur_write <= 1'b0;
      cur_word  <= 1'b0;
      cur_rom   <= 1'b0;
      cur_kbd   <= 1'b0;
      cur_lowmb <= 1'b0;
    end else if (take) begin
      cur_addr  <= req_addr;
      cur_wdata <= req_wdata;
      cur_owner <= req_owner;
      cur_io    <= req_io;
      cur_write <= req_write;
      cur_word  <= req_word;
      cur_rom   <= dec_rom;
      cur_kbd   <= dec_kbd;
      cur_lowmb <= dec_lowmb;
    end
  end

  // Width decided once the slave has seen the address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      is16     <= 1'b0;
      hi_phase <= 1'b0;
    end else begin
      if (state == ibcs_pkg::IBCS_ADDR && !hi_phase) begin
        is16 <= cur_word && !cur_addr[0] && size16;
      end
      if (take) begin
        hi_phase <= 1'b0;
      end else if (state == ibcs_pkg::IBCS_HOLD && split) begin
        hi_phase <= 1'b1;
      end
    end
  end

  // Read capture and completion pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= '0;
      done    <= 1'b0;
    end else begin
      done <= finish;
      if (cmd_end && !cur_write) begin
        if (hi_phase) begin
          rd_data[15:8] <= sd_in[7:0];
        end else if (is16) begin
          rd_data <= sd_in;
        end else begin
          rd_data[7:0] <= sd_in[7:0];
        end
      end
    end
  end

  // ****************************************
  // Strap and shared input
  // ****************************************
  // Strap is caught while reset is held, so the pin function is stable after
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strap <= multipurpose_strap_zero;
    end
  end

  // Local ready forwarded only when strapped that way
  always_ff @(posedge core_clk) begin
    if (rst) begin
      local_ready_n <= 1'b1;
    end else begin
      local_ready_n <= strap | zws_lrdy_in_n;
    end
  end

  // ****************************************
  // ROM and keyboard select
  // ****************************************
  // ROM enable rises at end of first T2, falls at end of last T2
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rom_oe  <= 1'b0;
      kbd_sel <= 1'b0;
    end else begin
      if (cmd_end) begin
        rom_oe <= 1'b0;
      end else if (in_cmd && wait_first && cur_rom) begin
        rom_oe <= 1'b1;
      end
      kbd_sel <= cur_kbd && next_state == ibcs_pkg::IBCS_CMD;
    end
  end

  assign bios_rom_select_n = !(rom_oe || kbd_sel);

  // ****************************************
  // Data and address pins
  // ****************************************
  // Data loaded at each address phase; in the second byte cycle the high byte rides both lanes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sd_out <= '0;
    end else if (state == ibcs_pkg::IBCS_ADDR) begin
      sd_out <= hi_phase ? {cur_wdata[15:8], cur_wdata[15:8]} : cur_wdata;
    end
  end

  // Only processor writes put data on the bus; DMA data comes from the card
  assign sd_oe = !master_active && cur_write && cur_owner == ibcs_pkg::OWN_CPU &&
                 (in_cmd || state == ibcs_pkg::IBCS_HOLD);

  assign sa_out = {cur_addr[1], cur_addr[0] | hi_phase};
  assign sa_oe  = !master_active;
  assign ale    = state == ibcs_pkg::IBCS_ADDR;

  // High byte enabled for even word or odd byte
  assign sbhe_out_n = !((cur_word && !hi_phase && !cur_addr[0]) || sa_out[0]);
  assign sbhe_oe    = !master_active;

  // ****************************************
  // Command strobes: {mem write, mem read, io write, io read}
  // ****************************************
  assign cmd_out_n[0] = !(in_cmd && cur_io && !cur_write);
  assign cmd_out_n[1] = !(in_cmd && cur_io && cur_write);
  assign cmd_out_n[2] = !(in_cmd && !cur_io && !cur_write);
  assign cmd_out_n[3] = !(in_cmd && !cur_io && cur_write);
  assign cmd_oe       = drive_cmd;

  assign low_megabyte_select_n = !(state != ibcs_pkg::IBCS_IDLE && cur_lowmb);

  // Memory select held low while a master owns the bus
  assign mcs16_out_n = 1'b0;
  assign mcs16_oe    = master_active;

  // ****************************************
  // Master-cycle sampling
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      master_sa     <= '0;
      master_sbhe_n <= 1'b1;
      master_cmd_n  <= 4'hF;
    end else if (master_active) begin
      master_sa     <= sa_in;
      master_sbhe_n <= sbhe_in_n;
      master_cmd_n  <= cmd_in_n;
    end
  end

endmodule

// [tb/ibcs_isa_slave.sv]
`timescale 1ns/100ps
// ****************************************
// ISA slave card model
// ****************************************
module ibcs_isa_slave (
  input  wire logic        core_clk,
  input  wire logic [3:0]  cmd_out_n,
  input  wire logic        cmd_oe,
  input  wire logic [1:0]  sa_out,
  input  wire logic [15:0] sd_out,
  input  wire logic        sd_oe,
  input  wire logic        mcs16_out_n,
  input  wire logic        mcs16_oe,
  input  wire logic        claim16,
  input  wire logic [7:0]  stall,
  input  wire logic        zws_on,
  output logic [15:0]      sd_in,
  output logic             iocs16_n,
  output logic             mcs16_in_n,
  output logic             iochrdy,
  output logic             zws_n,
  output logic [7:0]       wr_byte
);
  logic [7:0]  cnt     = 8'h00;  // Strobe-active cycles so far
  logic [15:0] last_sd = 16'h0000;  // Wire value last cycle
  logic        active;  // Some strobe is low
  logic        rd_on;  // Read strobe low
  assign active = cmd_oe && (cmd_out_n != 4'hF);
  assign rd_on  = active && (!cmd_out_n[2] || !cmd_out_n[0]);
  // Released bus toggles so stale data never looks valid
  assign sd_in = sd_oe ? sd_out : (rd_on ? {8'hC3, (sa_out[0] ? 8'hB2 : 8'hA1)} : ~last_sd);
  assign iocs16_n   = !claim16;
  assign mcs16_in_n = mcs16_oe ? mcs16_out_n : !claim16;
  assign iochrdy    = !(active && (cnt < stall));
  assign zws_n      = !(zws_on && active);
  // Count strobe cycles, latch write data
  always @(posedge core_clk) begin
    cnt     <= active ? cnt + 8'h01 : 8'h00;
    last_sd <= sd_in;
    if (active && (!cmd_out_n[3] || !cmd_out_n[1])) begin
      wr_byte <= sd_out[7:0];
    end
  end
endmodule

// [tb/ibcs_isa_cycle_props.sv]
`timescale 1ns/100ps
// ****************************************
// Pin behaviour checker
// ****************************************
module ibcs_isa_cycle_props (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_io,
  input wire logic [23:0] req_addr,
  input wire logic        master_active,
  input wire logic        kbd_disable,
  input wire logic        sa_oe,
  input wire logic        sbhe_oe,
  input wire logic        sd_oe,
  input wire logic        ale,
  input wire logic [3:0]  cmd_out_n,
  input wire logic        cmd_oe,
  input wire logic        mcs16_out_n,
  input wire logic        mcs16_oe,
  input wire logic        low_megabyte_select_n,
  input wire logic        bios_rom_select_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic take;  // Request accepted this edge
  logic cyc_kbd;  // Current cycle hits a keyboard port
  logic cmd_on;  // Strobe phase
  assign take   = req_valid && req_ready;
  assign cmd_on = cmd_out_n != 4'hF;
  // Remember whether the taken cycle is a keyboard access
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cyc_kbd <= 1'b0;
    end else if (take) begin
      cyc_kbd <= req_io && (req_addr[15:0] == 16'h0060 || req_addr[15:0] == 16'h0064);
    end
  end
  addr_drive_a: assert property (sa_oe == !master_active) else $error("address enable wrong");
  data_drive_a: assert property (sd_oe |-> !master_active) else $error("data driven under master");
  ale_start_a: assert property (take |=> ale ##1 !ale) else $error("ale pulse wrong");
  hbe_dir_a: assert property (sbhe_oe == !master_active) else $error("byte enable direction wrong");
  cmd_dir_a: assert property (master_active |-> !cmd_oe) else $error("strobes driven under master");
  low_mb_a: assert property (take && !req_io && req_addr[23:20] == 4'h0 |=> !low_megabyte_select_n)
    else $error("low megabyte flag missing");
  mcs_drive_a: assert property (master_active |-> mcs16_oe && !mcs16_out_n) else $error("mcs16 not low");
  rom_wait_a: assert property ($fell(bios_rom_select_n) && !cmd_out_n[2] |=> bios_rom_select_n)
    else $error("rom enable too long");
  kbd_sel_a: assert property (cmd_oe && cmd_on && cyc_kbd && !kbd_disable |-> ##[0:1] !bios_rom_select_n)
    else $error("keyboard select missing");
  kbd_off_a: assert property (cmd_on && cyc_kbd && kbd_disable |-> bios_rom_select_n)
    else $error("keyboard select not blocked");
endmodule
bind ibcs_isa_cycle ibcs_isa_cycle_props ibcs_isa_cycle_props_inst (.core_clk(core_clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .req_io(req_io), .req_addr(req_addr),
  .master_active(master_active), .kbd_disable(kbd_disable), .sa_oe(sa_oe), .sbhe_oe(sbhe_oe),
  .sd_oe(sd_oe), .ale(ale), .cmd_out_n(cmd_out_n), .cmd_oe(cmd_oe), .mcs16_out_n(mcs16_out_n),
  .mcs16_oe(mcs16_oe), .low_megabyte_select_n(low_megabyte_select_n), .bios_rom_select_n(bios_rom_select_n));

// [tb/ibcs_isa_cycle_tb.sv]
`timescale 1ns/100ps
module ibcs_isa_cycle_tb;
  // ****************************************
  // Stimulus and observed pins
  // ****************************************
  logic        core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_io = 1'b0, req_write = 1'b0;
  logic        req_word = 1'b0, master_active = 1'b0, rom_wide = 1'b0, kbd_disable = 1'b0;
  logic        strap = 1'b0, sbhe_in_n = 1'b1, claim16 = 1'b0, zws_on = 1'b0;
  logic [1:0]  req_owner = 2'h0, sa_in = 2'h0;
  logic [3:0]  cmd_in_n = 4'hF;
  logic [7:0]  stall = 8'h00;  // Ready hold-off length
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_wdata = 16'h0000, rdat;
  logic        req_ready, done, sa_oe, sd_oe, ale, sbhe_out_n, sbhe_oe, cmd_oe, lmb_n, mcs16_in_n;
  logic        mcs16_out_n, mcs16_oe, iocs16_n, iochrdy, zws_n, lr_n, rom_n, master_sbhe_n;
  logic [15:0] rd_data, sd_in, sd_out;
  logic [1:0]  sa_out, master_sa;
  logic [3:0]  cmd_out_n, master_cmd_n;
  logic [7:0]  wr_byte;
  int          n_mismatch = 0, comparisons = 0, n_cyc, sel_lo, lmb_lo, lr_lo, oe_hi;
  always #10 core_clk = ~core_clk;
  ibcs_isa_cycle ibcs_isa_cycle_inst (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_owner(req_owner), .req_io(req_io), .req_write(req_write), .req_word(req_word),
    .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rd_data(rd_data), .master_active(master_active),
    .rom_wide(rom_wide), .kbd_disable(kbd_disable), .multipurpose_strap_zero(strap), .sa_in(sa_in),
    .sa_out(sa_out), .sa_oe(sa_oe), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .ale(ale),
    .sbhe_in_n(sbhe_in_n), .sbhe_out_n(sbhe_out_n), .sbhe_oe(sbhe_oe), .cmd_in_n(cmd_in_n),
    .cmd_out_n(cmd_out_n), .cmd_oe(cmd_oe), .low_megabyte_select_n(lmb_n), .mcs16_in_n(mcs16_in_n),
    .mcs16_out_n(mcs16_out_n), .mcs16_oe(mcs16_oe), .iocs16_n(iocs16_n), .iochrdy(iochrdy),
    .zws_lrdy_in_n(zws_n), .local_ready_n(lr_n), .bios_rom_select_n(rom_n), .master_sa(master_sa),
    .master_sbhe_n(master_sbhe_n), .master_cmd_n(master_cmd_n));
  ibcs_isa_slave ibcs_isa_slave_inst (.core_clk(core_clk), .cmd_out_n(cmd_out_n), .cmd_oe(cmd_oe),
    .sa_out(sa_out), .sd_out(sd_out), .sd_oe(sd_oe), .mcs16_out_n(mcs16_out_n), .mcs16_oe(mcs16_oe),
    .claim16(claim16), .stall(stall), .zws_on(zws_on), .sd_in(sd_in), .iocs16_n(iocs16_n),
    .mcs16_in_n(mcs16_in_n), .iochrdy(iochrdy), .zws_n(zws_n), .wr_byte(wr_byte));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Strap is only looked at while reset is high
  task automatic do_reset(input logic s);
    @(posedge core_clk);
    rst   <= 1'b1;
    strap <= s;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  // One request; counts cycles from take to done and watches pins
  task automatic do_req(input logic [1:0] ow, input logic io, wr, wd, input logic [23:0] ad);
    @(posedge core_clk);
    {req_owner, req_io, req_write, req_word, req_addr} <= {ow, io, wr, wd, ad};
    req_wdata <= 16'hE75C;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    {n_cyc, sel_lo, lmb_lo, lr_lo, oe_hi} = '0;
    do begin
      @(posedge core_clk);
      #1;
      n_cyc++;
      sel_lo += int'(rom_n === 1'b0);
      lmb_lo += int'(lmb_n === 1'b0);
      lr_lo  += int'(lr_n === 1'b0);
      // Last sample falls in the idle cycle, where the strobes are always driven
      oe_hi  += int'(cmd_oe === 1'b1 && done !== 1'b1);
    end while (done !== 1'b1 && n_cyc < 40);
    // A transfer that never ends counts against the run
    if (done !== 1'b1) begin
      n_mismatch++;
    end
    rdat = rd_data;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_io;
    do_req(2'h0, 1'b1, 1'b0, 1'b0, 24'h000300);
    chk("byte cycles", 16'd7, 16'(n_cyc));
    chk("byte data", 16'h00A1, {8'h00, rdat[7:0]});
    do_req(2'h0, 1'b1, 1'b0, 1'b1, 24'h000300);
    chk("split cycles", 16'd14, 16'(n_cyc));
    chk("split data", 16'hB2A1, rdat);
    claim16 = 1'b1;
    do_req(2'h0, 1'b1, 1'b0, 1'b1, 24'h000300);
    chk("wide cycles", 16'd4, 16'(n_cyc));
    chk("wide data", 16'hC3A1, rdat);
    chk("word hbe", 16'h0000, 16'(sbhe_out_n));
    // Memory word claimed by the slave's memory select
    do_req(2'h0, 1'b0, 1'b0, 1'b1, 24'h0C8000);
    chk("mem wide cycles", 16'd4, 16'(n_cyc));
    chk("mem wide data", 16'hC3A1, rdat);
    claim16 = 1'b0;
    stall   = 8'd8;
    do_req(2'h0, 1'b1, 1'b0, 1'b0, 24'h000300);
    chk("stretched", 16'd11, 16'(n_cyc));
    stall = 8'd0;
  endtask
  // Refresh leaves strobes undriven and sits above 1 MB
  task automatic t_owner;
    for (int ow = 0; ow < 3; ow++) begin
      do_req(2'(ow), 1'b0, 1'b1, 1'b0, (ow == 2) ? 24'h200000 : 24'h0C8000);
      chk("low mb", 16'(ow != 2), 16'(lmb_lo > 0));
      chk("strobe drive", 16'(ow != 2), 16'(oe_hi > 0));
      if (ow == 0) chk("write byte", 16'h005C, {8'h00, wr_byte});
    end
    do_req(2'h0, 1'b0, 1'b1, 1'b0, 24'h100000);
    chk("high mem", 16'h0000, 16'(lmb_lo > 0));
  endtask
  // Ready held off on purpose: the ROM cycle must ignore it
  task automatic t_rom;
    for (int w = 0; w < 2; w++) begin
      rom_wide <= w[0];
      stall = 8'd6;
      do_req(2'h0, 1'b0, 1'b0, 1'b1, 24'h0F0000);
      chk("rom cycles", w ? 16'd4 : 16'd8, 16'(n_cyc));
      chk("rom enable", w ? 16'd1 : 16'd2, 16'(sel_lo));
      chk("rom data", w ? 16'hC3A1 : 16'hB2A1, rdat);
    end
    stall = 8'd0;
  endtask
  task automatic t_kbd;
    for (int i = 0; i < 4; i++) begin
      kbd_disable <= i[1];
      do_req(2'h0, 1'b1, 1'b0, 1'b0, i[0] ? 24'h000064 : 24'h000060);
      chk("kbd select", 16'(!i[1]), 16'(sel_lo > 0));
    end
    kbd_disable <= 1'b0;
  endtask
  task automatic t_strap;
    zws_on = 1'b1;
    do_reset(1'b0);
    do_req(2'h0, 1'b1, 1'b0, 1'b0, 24'h000300);
    chk("local ready", 16'h0001, 16'(lr_lo > 0));
    chk("no early end", 16'd7, 16'(n_cyc));
    do_reset(1'b1);
    do_req(2'h0, 1'b1, 1'b0, 1'b0, 24'h000300);
    chk("zero wait", 16'd3, 16'(n_cyc));
    chk("ready idle", 16'h0000, 16'(lr_lo));
    zws_on = 1'b0;
  endtask
  task automatic t_master;
    @(posedge core_clk);
    {master_active, sa_in, sbhe_in_n, cmd_in_n} <= {1'b1, 2'h2, 1'b0, 4'hD};
    repeat (3) @(posedge core_clk);
    #1;
    chk("ready", 16'h0000, 16'(req_ready));
    chk("sa oe", 16'h0000, 16'(sa_oe));
    chk("master sa", 16'h0002, 16'(master_sa));
    chk("master hbe", 16'h0000, 16'(master_sbhe_n));
    chk("master cmd", 16'h000D, 16'(master_cmd_n));
    chk("mcs16", 16'h0000, 16'(mcs16_out_n | !mcs16_oe));
    @(posedge core_clk);
    master_active <= 1'b0;
  endtask
  // ****************************************
  // Verdict and run control
  // ****************************************
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run is about 220 cycles; allow ample margin
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
  initial begin
    do_reset(1'b0);
    t_io();
    t_owner();
    t_rom();
    t_kbd();
    t_master();
    t_strap();
    results();
  end
endmodule
